// [i2ctp_pkg.sv]
package i2ctp_pkg;
    // Core clock period
    localparam int CLK_NS = 5;
    // Fixed parts of the target address, top two bits and bits 2..0
    localparam logic [1:0] ADDR_FIX_TOP = 2'h1;
    localparam logic [2:0] ADDR_FIX_LOW = 3'h7;
    // Field positions of the 8-bit address byte
    localparam int ADDR_POS_HI = 5;
    localparam int ADDR_POS_LO = 4;
    localparam int ADDR_POS_RW = 0;
    // Bits per byte and bit slots per byte with acknowledge
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] SLOT_BITS = 4'h9;
    // Bus times in ns, standard and fast mode
    localparam int T_LOW_SM_NS = 4700;
    localparam int T_HIGH_SM_NS = 4000;
    localparam int T_LOW_FM_NS = 1300;
    localparam int T_HIGH_FM_NS = 600;
    localparam int T_SU_DAT_NS = 250;
    // Least times rounded up to whole core cycles
    localparam logic [9:0] T_LOW_SM_CYC = 10'((T_LOW_SM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] T_HIGH_SM_CYC = 10'((T_HIGH_SM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] T_LOW_FM_CYC = 10'((T_LOW_FM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] T_HIGH_FM_CYC = 10'((T_HIGH_FM_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] T_SU_DAT_CYC = 6'((T_SU_DAT_NS + CLK_NS - 1) / CLK_NS);
endpackage

// [i2ctp_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface i2ctp_bus_if;
    // Target drive: value and active-low enable per line
    logic tgt_scl_o;
    logic tgt_scl_oe_n;
    logic tgt_sda_o;
    logic tgt_sda_oe_n;
    // Controller drive
    logic ctl_scl_o;
    logic ctl_scl_oe_n;
    logic ctl_sda_o;
    logic ctl_sda_oe_n;
    // Attention line, low while an enabled event is pending
    logic host_attention_n;
    // Wired-AND lines with pull-ups
    logic scl;
    logic sda;
    assign scl = !((!tgt_scl_oe_n && !tgt_scl_o) || (!ctl_scl_oe_n && !ctl_scl_o));
    assign sda = !((!tgt_sda_oe_n && !tgt_sda_o) || (!ctl_sda_oe_n && !ctl_sda_o));
    modport target (
        input scl, sda,
        output tgt_scl_o, tgt_scl_oe_n, tgt_sda_o, tgt_sda_oe_n, host_attention_n
    );
    modport controller (
        input scl, sda, host_attention_n,
        output ctl_scl_o, ctl_scl_oe_n, ctl_sda_o, ctl_sda_oe_n
    );
endinterface
`default_nettype wire

// [i2ctp_target.sv]
`timescale 1ns/1ps
`default_nettype none
module i2ctp_target (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Two-wire bus
    i2ctp_bus_if.target bus,
    // Boot completion and address straps, asynchronous pins
    input wire logic boot_done_i,
    input wire logic addr_strap_lo_i,
    input wire logic addr_strap_hi_i,
    // Events and their enable mask from application logic
    input wire logic [7:0] event_i,
    input wire logic [7:0] event_mask_i,
    // Received bytes towards the command logic
    output logic [7:0] rx_data_o,
    output logic rx_subaddr_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // Bytes to send for reads
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // Address in use, valid once addr_ok_o is high
    output logic [6:0] own_addr_o,
    output logic addr_ok_o
);
    // One-hot protocol states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK = 9'h004,
        ST_RX = 9'h008,
        ST_RX_HOLD = 9'h010,
        ST_TX_HOLD = 9'h020,
        ST_TX = 9'h040,
        ST_TX_ACK = 9'h080,
        ST_IGNORE = 9'h100
    } i2ctp_state_e;

    i2ctp_state_e state; // Protocol state
    logic [2:0] scl_sync; // SCL synchroniser and previous sample
    logic [2:0] sda_sync; // SDA synchroniser and previous sample
    logic [1:0] boot_sync; // Boot-done synchroniser
    logic [1:0] hi_sync; // High strap synchroniser
    logic [1:0] lo_sync; // Low strap synchroniser
    logic [7:0] shift; // Byte shifter, both directions
    logic [3:0] bit_cnt; // Bits moved in the current byte
    logic rw; // Direction bit of the address byte
    logic first; // Next written byte is the sub-address
    logic nack; // Controller left acknowledge high
    logic [5:0] su_cnt; // Data setup delay before SCL release
    logic attn_n; // Registered attention level

    // Edge and condition decoding on synchronised lines
    wire scl_s = scl_sync[1];
    wire scl_q = scl_sync[2];
    wire sda_s = sda_sync[1];
    wire sda_q = sda_sync[2];
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_cond = scl_s && scl_q && sda_q && !sda_s;
    wire stop_cond = scl_s && scl_q && !sda_q && sda_s;
    wire addr_match = shift[7:1] == own_addr_o;
    wire byte_done = bit_cnt == i2ctp_pkg::BYTE_BITS;
    wire next_attn_n = ~|(event_i & event_mask_i);

    // Line drive: stretch in the hold states and during data setup
    wire hold_scl = (state == ST_RX_HOLD) || (state == ST_TX_HOLD)
        || ((state == ST_TX) && (su_cnt != 6'h00));
    wire drive_sda = (state == ST_ACK) || (state == ST_RX_HOLD)
        || ((state == ST_TX) && !shift[7]);

    assign bus.tgt_scl_o = 1'b0;
    assign bus.tgt_sda_o = 1'b0;
    assign bus.tgt_scl_oe_n = !hold_scl;
    assign bus.tgt_sda_oe_n = !drive_sda;
    assign bus.host_attention_n = attn_n;
    assign tx_ready_o = state == ST_TX_HOLD;

    // Input synchronisers; logic reads the second stage, and the third as previous sample for SCL and SDA
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            boot_sync <= 2'h0;
            hi_sync <= 2'h0;
            lo_sync <= 2'h0;
        end else begin
            scl_sync <= {scl_sync[1:0], bus.scl};
            sda_sync <= {sda_sync[1:0], bus.sda};
            boot_sync <= {boot_sync[0], boot_done_i};
            hi_sync <= {hi_sync[0], addr_strap_hi_i};
            lo_sync <= {lo_sync[0], addr_strap_lo_i};
        end
    end

    // Address taken once when boot completes; straps are static levels
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            addr_ok_o <= 1'b0;
            own_addr_o <= 7'h00;
        end else if (boot_sync[1] && !addr_ok_o) begin
            addr_ok_o <= 1'b1;
            own_addr_o <= {i2ctp_pkg::ADDR_FIX_TOP, hi_sync[1], lo_sync[1],
                i2ctp_pkg::ADDR_FIX_LOW};
        end
    end

    // Attention line follows unmasked events; a flop keeps it glitch free
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            attn_n <= 1'b1;
        end else begin
            attn_n <= next_attn_n;
        end
    end

    // Protocol engine; edges are seen three core cycles late, well
    // inside the shortest fast-mode low phase, so both speeds work
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            rw <= 1'b0;
            first <= 1'b0;
            nack <= 1'b0;
            su_cnt <= 6'h00;
            rx_data_o <= 8'h00;
            rx_subaddr_o <= 1'b0;
            rx_valid_o <= 1'b0;
        end else if (!addr_ok_o) begin
            // Deaf until the address is configured
            state <= ST_IDLE;
        end else if (start_cond) begin
            // Start or repeated start from any state
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            rx_valid_o <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            rx_valid_o <= 1'b0;
        end else begin
            if (su_cnt != 6'h00) begin
                su_cnt <= su_cnt - 6'h01;
            end
            case (state)
                ST_ADDR, ST_RX: begin
                    // Sample on SCL rise, MSB first
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (state == ST_RX) begin
                            // Hand the byte over and stretch until taken
                            rx_data_o <= shift;
                            rx_subaddr_o <= first;
                            rx_valid_o <= 1'b1;
                            first <= 1'b0;
                            state <= ST_RX_HOLD;
                        end else if (addr_match) begin
                            rw <= shift[i2ctp_pkg::ADDR_POS_RW];
                            first <= 1'b1;
                            state <= ST_ACK;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_RX_HOLD: begin
                    // SDA already low; SCL let go once the byte is taken
                    if (rx_ready_i) begin
                        rx_valid_o <= 1'b0;
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    // Acknowledge ends on the ninth SCL fall
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        state <= rw ? ST_TX_HOLD : ST_RX;
                    end
                end
                ST_TX_HOLD: begin
                    // Stretch after the acknowledge until data arrives
                    if (tx_valid_i) begin
                        shift <= tx_data_i;
                        bit_cnt <= 4'h0;
                        su_cnt <= i2ctp_pkg::T_SU_DAT_CYC;
                        state <= ST_TX;
                    end
                end
                ST_TX: begin
                    // Next bit goes out on each SCL fall
                    if (scl_fall) begin
                        shift <= {shift[6:0], 1'b1};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == i2ctp_pkg::BYTE_BITS - 4'h1) begin
                            state <= ST_TX_ACK;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // Released; read the controller's answer
                    if (scl_rise) begin
                        nack <= sda_s;
                    end else if (scl_fall) begin
                        state <= nack ? ST_IGNORE : ST_TX_HOLD;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    // Wait for the next start
                    state <= state;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [i2ctp_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module i2ctp_controller (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Two-wire bus
    i2ctp_bus_if.controller bus,
    // Speed select, high for fast mode
    input wire logic fast_mode_i,
    // Command port: 0 start+byte, 1 write, 2 read, 3 stop
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_kind_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_last_i,
    output logic cmd_ready_o,
    // Byte results
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_nack_o,
    // Target attention, synchronised, active high
    output logic attention_o
);
    // One-hot bus states
    typedef enum logic [9:0] {
        CS_IDLE = 10'h001,
        CS_START = 10'h002,
        CS_LOW = 10'h004,
        CS_HIGH = 10'h008,
        CS_HELD = 10'h010,
        CS_R_LO = 10'h020,
        CS_R_HI = 10'h040,
        CS_S_LO = 10'h080,
        CS_S_HI = 10'h100,
        CS_S_END = 10'h200
    } i2ctp_cstate_e;

    // Command codes
    localparam logic [1:0] CMD_START = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_READ = 2'h2;
    localparam logic [1:0] CMD_STOP = 2'h3;

    i2ctp_cstate_e state; // Bus state
    logic [2:0] scl_sync; // SCL synchroniser and previous sample
    logic [2:0] sda_sync; // SDA synchroniser and previous sample
    logic [1:0] attn_sync; // Attention synchroniser
    logic [9:0] tmr; // Phase timer in core cycles
    logic [8:0] tx9; // Bits to drive, acknowledge slot last
    logic [8:0] rx9; // Bits seen on SDA
    logic [3:0] bit_cnt; // Slots done in this byte
    logic busy; // Bus between a start and a stop

    wire scl_s = scl_sync[1];
    wire scl_q = scl_sync[2];
    wire sda_s = sda_sync[1];
    wire sda_q = sda_sync[2];
    wire t_low_done = tmr >= (fast_mode_i ? i2ctp_pkg::T_LOW_FM_CYC : i2ctp_pkg::T_LOW_SM_CYC);
    wire t_high_done = tmr >= (fast_mode_i ? i2ctp_pkg::T_HIGH_FM_CYC
        : i2ctp_pkg::T_HIGH_SM_CYC);
    wire bus_free = !busy && scl_s && sda_s;
    wire take = cmd_valid_i && cmd_ready_o;
    // Write bytes end with a released slot, reads ACK unless last
    wire [8:0] next_tx9 = (cmd_kind_i == CMD_READ) ? {8'hff, cmd_last_i}
        : {cmd_data_i, 1'b1};

    // Ready only on a free bus or with SCL held after a byte
    assign cmd_ready_o = ((state == CS_IDLE) && bus_free) || (state == CS_HELD);
    assign attention_o = !attn_sync[1];
    assign bus.ctl_scl_o = 1'b0;
    assign bus.ctl_sda_o = 1'b0;
    assign bus.ctl_scl_oe_n = !((state == CS_LOW) || (state == CS_HELD)
        || (state == CS_R_LO) || (state == CS_S_LO));
    assign bus.ctl_sda_oe_n = !((state == CS_START) || (state == CS_S_LO)
        || (state == CS_S_HI) || (((state == CS_LOW) || (state == CS_HIGH)) && !tx9[8]));

    // Synchronisers and bus busy tracking from start and stop
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            attn_sync <= 2'h3;
            busy <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[1:0], bus.scl};
            sda_sync <= {sda_sync[1:0], bus.sda};
            attn_sync <= {attn_sync[0], bus.host_attention_n};
            if (scl_s && scl_q && sda_q && !sda_s) begin
                busy <= 1'b1;
            end else if (scl_s && scl_q && !sda_q && sda_s) begin
                busy <= 1'b0;
            end
        end
    end

    // Bus sequencer; high phases are timed from SCL seen high
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= CS_IDLE;
            tmr <= 10'h000;
            tx9 <= 9'h1ff;
            rx9 <= 9'h000;
            bit_cnt <= 4'h0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            rsp_nack_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            tmr <= tmr + 10'h001;
            case (state)
                CS_IDLE: begin
                    // Other commands on an idle bus are dropped
                    if (take && (cmd_kind_i == CMD_START)) begin
                        tx9 <= next_tx9;
                        tmr <= 10'h000;
                        state <= CS_START;
                    end
                end
                CS_START: begin
                    // SDA low under high SCL, then first low phase
                    if (t_high_done) begin
                        bit_cnt <= 4'h0;
                        tmr <= 10'h000;
                        state <= CS_LOW;
                    end
                end
                CS_LOW: begin
                    if (t_low_done) begin
                        tmr <= 10'h000;
                        state <= CS_HIGH;
                    end
                end
                CS_HIGH: begin
                    // A stretched SCL keeps the timer at zero
                    if (!scl_s) begin
                        tmr <= 10'h000;
                    end else if (t_high_done) begin
                        rx9 <= {rx9[7:0], sda_s};
                        tx9 <= {tx9[7:0], 1'b1};
                        bit_cnt <= bit_cnt + 4'h1;
                        tmr <= 10'h000;
                        if (bit_cnt == i2ctp_pkg::SLOT_BITS - 4'h1) begin
                            rsp_valid_o <= 1'b1;
                            rsp_data_o <= rx9[7:0];
                            rsp_nack_o <= sda_s;
                            state <= CS_HELD;
                        end else begin
                            state <= CS_LOW;
                        end
                    end
                end
                CS_HELD: begin
                    // SCL held low, SDA released between bytes
                    if (take) begin
                        tmr <= 10'h000;
                        bit_cnt <= 4'h0;
                        tx9 <= next_tx9;
                        if (cmd_kind_i == CMD_STOP) begin
                            state <= CS_S_LO;
                        end else if (cmd_kind_i == CMD_START) begin
                            state <= CS_R_LO;
                        end else begin
                            state <= CS_LOW;
                        end
                    end
                end
                CS_R_LO: begin
                    if (t_low_done) begin
                        tmr <= 10'h000;
                        state <= CS_R_HI;
                    end
                end
                CS_R_HI, CS_S_HI: begin
                    // Both wait for SCL really high before timing
                    if (!scl_s) begin
                        tmr <= 10'h000;
                    end else if (t_high_done) begin
                        tmr <= 10'h000;
                        state <= (state == CS_R_HI) ? CS_START : CS_S_END;
                    end
                end
                CS_S_LO: begin
                    if (t_low_done) begin
                        tmr <= 10'h000;
                        state <= CS_S_HI;
                    end
                end
                CS_S_END: begin
                    // Bus free time before the next start
                    if (t_low_done) begin
                        state <= CS_IDLE;
                    end
                end
                default: begin
                    state <= CS_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [i2ctp_props.sv]
`timescale 1ns/1ps
`default_nettype none
module i2ctp_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Resolved lines and drive enables
    input wire logic scl,
    input wire logic sda,
    input wire logic tgt_scl_oe_n,
    input wire logic tgt_sda_oe_n,
    input wire logic ctl_sda_oe_n
);
    // Line levels one cycle back
    logic scl_q;
    logic sda_q;
    // SCL rises since the last start, wraps 9 to 1
    logic [3:0] slot;
    // SDA edges while SCL stays high
    wire start_w = scl && scl_q && sda_q && !sda;
    wire stop_w = scl && scl_q && !sda_q && sda;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Edge history and slot count, reset to idle lines
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            slot <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            // Stop clock rise lands on 1 when bytes were whole
            if (start_w) begin
                slot <= 4'h0;
            end else if (scl && !scl_q) begin
                slot <= (slot == 4'h9) ? 4'h1 : slot + 4'h1;
            end
        end
    end
    sequence s_start;
        start_w;
    endsequence
    sequence s_stop;
        stop_w;
    endsequence
    property p_start_src;
        s_start |-> !ctl_sda_oe_n && tgt_sda_oe_n;
    endproperty
    property p_stop_rel;
        s_stop |=> (tgt_sda_oe_n && tgt_scl_oe_n) [*8];
    endproperty
    property p_bus_free;
        s_stop |=> (scl && sda) [*8];
    endproperty
    property p_sda_hold;
        scl && scl_q |-> $stable(tgt_sda_oe_n);
    endproperty
    property p_ack_low;
        $rose(scl) && !tgt_sda_oe_n |-> (!sda) [*8];
    endproperty
    property p_stretch;
        $fell(tgt_scl_oe_n) |-> !scl_q;
    endproperty
    property p_high_min;
        $rose(scl) |-> scl [*8];
    endproperty
    property p_byte_slots;
        s_stop |-> slot == 4'h1;
    endproperty
    a_start_src: assert property (p_start_src) else $error("start not made by controller");
    a_stop_rel: assert property (p_stop_rel) else $error("target drives after stop");
    a_bus_free: assert property (p_bus_free) else $error("bus busy right after stop");
    a_sda_hold: assert property (p_sda_hold) else $error("target SDA moved, SCL high");
    a_ack_low: assert property (p_ack_low) else $error("target low not held");
    a_stretch: assert property (p_stretch) else $error("stretch began in high phase");
    a_high_min: assert property (p_high_min) else $error("SCL high phase too short");
    a_byte_slots: assert property (p_byte_slots) else $error("partial byte at stop");
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Clock, reset, boot and straps
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic boot_done_i = 1'b0;
    logic addr_strap_lo = 1'b1;
    logic addr_strap_hi = 1'b0;
    // Events, user side of target, controller commands
    logic [7:0] event_i = 8'h10;
    logic [7:0] event_mask_i = 8'h00;
    logic rx_ready_i = 1'b0;
    logic [7:0] tx_data_i = 8'ha5;
    logic tx_valid_i = 1'b0;
    logic fast_mode_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_kind_i = 2'h0;
    logic [7:0] cmd_data_i = 8'h00;
    logic cmd_last_i = 1'b0;
    // Design outputs
    logic [7:0] rx_data_o, rsp_data_o;
    logic rx_subaddr_o, rx_valid_o, tx_ready_o, addr_ok_o;
    logic cmd_ready_o, rsp_valid_o, rsp_nack_o, attention_o;
    logic [6:0] own_addr_o;
    // Counters and the log of bytes handed over
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int hold = 0;
    logic [8:0] rx_log [$];
    i2ctp_bus_if link ();
    i2ctp_target i2ctp_target_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus(link),
        .boot_done_i(boot_done_i), .addr_strap_lo_i(addr_strap_lo),
        .addr_strap_hi_i(addr_strap_hi), .event_i(event_i), .event_mask_i(event_mask_i),
        .rx_data_o(rx_data_o), .rx_subaddr_o(rx_subaddr_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .own_addr_o(own_addr_o), .addr_ok_o(addr_ok_o));
    i2ctp_controller i2ctp_controller_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .bus(link), .fast_mode_i(fast_mode_i), .cmd_valid_i(cmd_valid_i),
        .cmd_kind_i(cmd_kind_i), .cmd_data_i(cmd_data_i), .cmd_last_i(cmd_last_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_nack_o(rsp_nack_o), .attention_o(attention_o));
    i2ctp_props i2ctp_props_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl(link.scl),
        .sda(link.sda), .tgt_scl_oe_n(link.tgt_scl_oe_n), .tgt_sda_oe_n(link.tgt_sda_oe_n),
        .ctl_sda_oe_n(link.ctl_sda_oe_n));
    // Core clock
    always #(i2ctp_pkg::CLK_NS / 2.0) sys_clk_i = ~sys_clk_i;
    // Slow consumer forces stretching, producer answers at once
    // Consumer waits longer than a fast low phase so the hold shows on SCL
    always @(negedge sys_clk_i) begin
        hold = (rx_valid_o === 1'b1) ? hold + 1 : 0;
        rx_ready_i = (hold == 400);
        if (hold == 400) begin
            rx_log.push_back({rx_subaddr_o, rx_data_o});
            hold = 0;
        end
        // A byte was taken last edge, so the next one differs
        if (tx_valid_i) begin
            tx_data_i = ~tx_data_i;
        end
        tx_valid_i = (tx_ready_o === 1'b1) && !tx_valid_i;
    end
    // Hang guard, well above the expected run length
    always @(posedge sys_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 90000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One controller command; waits for the byte result if any
    task automatic cmd(input logic [1:0] kind, input logic [7:0] data, input logic last);
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b1;
        cmd_kind_i = kind;
        cmd_data_i = data;
        cmd_last_i = last;
        @(posedge sys_clk_i iff cmd_ready_o === 1'b1);
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        if (kind != 2'h3) begin
            @(posedge sys_clk_i iff rsp_valid_o === 1'b1);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        // Silent before boot sets the address
        cmd(2'h0, 8'h5e, 1'b0);
        chk("nack before boot", rsp_nack_o, 9'h1);
        cmd(2'h3, 8'h00, 1'b0);
        chk("addr_ok before boot", addr_ok_o, 9'h0);
        boot_done_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        chk("own address", {addr_ok_o, own_addr_o}, 9'h0af);
        // Foreign address left unanswered
        cmd(2'h0, 8'h7e, 1'b0);
        chk("foreign nack", rsp_nack_o, 9'h1);
        cmd(2'h3, 8'h00, 1'b0);
        // Write: sub-address then one data byte
        cmd(2'h0, 8'h5e, 1'b0);
        chk("write address ack", rsp_nack_o, 9'h0);
        cmd(2'h1, 8'h1a, 1'b0);
        chk("sub-address ack", rsp_nack_o, 9'h0);
        cmd(2'h1, 8'hc3, 1'b0);
        chk("data ack", rsp_nack_o, 9'h0);
        cmd(2'h3, 8'h00, 1'b0);
        chk("rx count", 9'(rx_log.size()), 9'h2);
        chk("rx sub-address", rx_log[0], 9'h11a);
        chk("rx data", rx_log[1], 9'h0c3);
        // Read two bytes, last one refused
        cmd(2'h0, 8'h5f, 1'b0);
        chk("read address ack", rsp_nack_o, 9'h0);
        cmd(2'h2, 8'h00, 1'b0);
        chk("read byte 1", rsp_data_o, 9'h0a5);
        cmd(2'h2, 8'h00, 1'b1);
        chk("read byte 2", rsp_data_o, 9'h05a);
        cmd(2'h3, 8'h00, 1'b0);
        // Standard mode address phase
        fast_mode_i = 1'b0;
        cmd(2'h0, 8'h5e, 1'b0);
        chk("std mode ack", rsp_nack_o, 9'h0);
        cmd(2'h3, 8'h00, 1'b0);
        // Attention follows only enabled events
        chk("attention masked", attention_o, 9'h0);
        event_mask_i = 8'h10;
        repeat (8) @(negedge sys_clk_i);
        chk("attention enabled", attention_o, 9'h1);
        event_mask_i = 8'hef;
        repeat (8) @(negedge sys_clk_i);
        chk("attention other bits", attention_o, 9'h0);
        complete_run();
    end
endmodule
`default_nettype wire
